//--- src/exc_seq.sv
// Exception sequencer: detects exceptions, saves state, fetches vectors.
// ==========================================================================
// Summary of operation
// - Reset handling starts when reset pin releases.
// - Address error, interrupt wait for instruction completion.
// - Trap handling starts on trap execution.
// - Undefined opcode outside slot: general illegal.
// - Undefined or PC-writing slot opcode: slot illegal.
// - Reset fetches PC at zero, SP at four.
// - Reset clears vector base, sets mask ones.
// - Push status word and PC on stack.
// - Interrupt writes its level into mask field.
// - Other exceptions leave mask field unchanged.
// - Fetch handler address from table, jump there.
// - Distinct vectors; entry address from vector offset.
// - Vectors four, six, nine for illegal/address.
// - NMI uses vector eleven, offset four times.
// - Trap vectors thirty-two to sixty-three.
`timescale 1ns/10ps
`include "exc_seq_consts.svh"

module exc_seq
    import exc_seq_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    input  wire logic        DEC_VALID,
    input  wire logic        DEC_UNDEF,
    input  wire logic        DEC_IN_SLOT,
    input  wire logic        DEC_PC_WRITE,
    input  wire logic        DEC_ADDR_ERR,
    input  wire logic        INSN_DONE,
    input  wire logic        TRAP_EXEC,
    input  wire logic [7:0]  TRAP_VEC,
    input  wire logic        IRQ_REQ,
    input  wire logic        IRQ_NMI,
    input  wire logic [3:0]  IRQ_LEVEL,
    input  wire logic [7:0]  IRQ_VEC,
    output logic             IRQ_ACK,
    input  wire logic [31:0] RET_PC,
    input  wire logic [31:0] SR_IN,
    input  wire logic [31:0] SP_IN,
    output logic             MEM_REQ,
    output logic             MEM_WE,
    output logic [31:0]      MEM_ADDR,
    output logic [31:0]      MEM_WDATA,
    input  wire logic        MEM_ACK,
    input  wire logic [31:0] MEM_RDATA,
    output logic             BUSY,
    output logic             PC_LOAD,
    output logic [31:0]      PC_VALUE,
    output logic             SP_LOAD,
    output logic [31:0]      SP_VALUE,
    output logic             SR_LOAD,
    output logic [31:0]      SR_VALUE,
    output logic [31:0]      VEC_BASE,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic [31:0]      REG_RDATA,
    output logic             INT_OUT
);

    // ======================================================================
    // Helpers
    // Table entry address: base plus four bytes per vector.
    function automatic logic [31:0] vec_addr(input logic [31:0] base, input logic [7:0] vec);
        vec_addr = base + {22'h0, vec, 2'b00};
    endfunction

    // Status word with a new interrupt mask field.
    function automatic logic [31:0] with_mask(input logic [31:0] sr, input logic [3:0] m);
        logic [31:0] r;
        r = sr;
        r[`IMASK_LSB +: 4] = m;
        with_mask = r;
    endfunction

    seq_regs_t q;
    seq_regs_t d;
    logic      mem_state;
    logic      start_pend;
    logic      start_ill;
    logic      start_trap;
    logic [5:0] ev_set;
    logic [5:0] ev_clr;

    // ======================================================================
    // Next-state logic
    // Memory is requested in every state that reads or writes the table or stack.
    assign mem_state = (q.st == ST_RST_PC) || (q.st == ST_RST_SP) || (q.st == ST_PUSH_SR) ||
                       (q.st == ST_PUSH_PC) || (q.st == ST_VEC);
    // Pending address error or interrupt starts once the running instruction ends.
    assign start_pend = (q.st == ST_IDLE) && INSN_DONE && (q.pend_ae || q.pend_irq);
    // Illegal opcodes start straight from decode.
    assign start_ill = (q.st == ST_IDLE) && !start_pend && DEC_VALID &&
                       (DEC_UNDEF || (DEC_IN_SLOT && DEC_PC_WRITE));
    assign start_trap = (q.st == ST_IDLE) && !start_pend && !start_ill && TRAP_EXEC;

    always_comb
    begin
        d = q;
        ev_set = 6'h00;
        ev_clr = 6'h00;
        d.pc_load = 1'b0;
        d.sp_load = 1'b0;
        d.sr_load = 1'b0;
        d.irq_ack = 1'b0;
        d.rdata = 32'h0000_0000;
        // Catch address errors and interrupts seen at decode until they start.
        if (DEC_VALID && DEC_ADDR_ERR)
        begin
            d.pend_ae = 1'b1;
        end
        if (DEC_VALID && IRQ_REQ && !q.pend_irq)
        begin
            d.pend_irq = 1'b1;
            d.pend_lvl = IRQ_LEVEL;
            d.pend_vec = IRQ_NMI ? `VEC_NMI : IRQ_VEC;
        end
        case (q.st)
            ST_IDLE:
            begin
                if (start_pend || start_ill || start_trap)
                begin
                    d.st = ST_PUSH_SR;
                    d.is_reset = 1'b0;
                    d.is_irq = 1'b0;
                    d.sr_save = SR_IN;
                    d.sp = SP_IN;
                    d.pc = RET_PC;
                    d.mem_we = 1'b1;
                    d.mem_addr = SP_IN - `STACK_WORD;
                    d.mem_wdata = SR_IN;
                    if (start_pend && q.pend_ae)
                    begin
                        d.vec = `VEC_ADDR_ERROR;
                        d.pend_ae = 1'b0;
                        ev_set[`EVT_ADDR_ERR] = 1'b1;
                    end
                    else if (start_pend)
                    begin
                        d.vec = q.pend_vec;
                        d.is_irq = 1'b1;
                        d.irq_lvl = q.pend_lvl;
                        d.pend_irq = 1'b0;
                        d.irq_ack = 1'b1;
                        ev_set[`EVT_IRQ] = 1'b1;
                    end
                    else if (start_ill && DEC_IN_SLOT)
                    begin
                        d.vec = `VEC_SLOT_ILLEGAL;
                        ev_set[`EVT_SLOT_ILL] = 1'b1;
                    end
                    else if (start_ill)
                    begin
                        d.vec = `VEC_GEN_ILLEGAL;
                        ev_set[`EVT_GEN_ILL] = 1'b1;
                    end
                    else
                    begin
                        // Trap numbers are folded into the user range.
                        d.vec = `VEC_TRAP_FIRST | (TRAP_VEC & 8'h1f);
                        ev_set[`EVT_TRAP] = 1'b1;
                    end
                end
            end
            ST_RST_PC:
            begin
                if (MEM_ACK)
                begin
                    d.pc = MEM_RDATA;
                    d.st = ST_RST_SP;
                    d.mem_addr = `RESET_SP_ADDR;
                end
            end
            ST_RST_SP:
            begin
                if (MEM_ACK)
                begin
                    d.sp = MEM_RDATA;
                    d.st = ST_FINISH;
                end
            end
            ST_PUSH_SR:
            begin
                if (MEM_ACK)
                begin
                    d.st = ST_PUSH_PC;
                    d.mem_addr = q.sp - (`STACK_WORD + `STACK_WORD);
                    d.mem_wdata = q.pc;
                end
            end
            ST_PUSH_PC:
            begin
                if (MEM_ACK)
                begin
                    d.st = ST_VEC;
                    d.sp = q.sp - (`STACK_WORD + `STACK_WORD);
                    d.mem_we = 1'b0;
                    d.mem_addr = vec_addr(q.vector_base_reg, q.vec);
                    d.mem_wdata = 32'h0000_0000;
                end
            end
            ST_VEC:
            begin
                if (MEM_ACK)
                begin
                    d.pc = MEM_RDATA;
                    d.st = ST_FINISH;
                end
            end
            ST_FINISH:
            begin
                // Hand the new PC, SP and status word to the core in one cycle.
                d.st = ST_IDLE;
                d.pc_load = 1'b1;
                d.sp_load = 1'b1;
                d.sr_load = 1'b1;
                if (q.is_reset)
                begin
                    d.vector_base_reg = `VEC_BASE_RESET;
                    d.sr_val = with_mask(SR_IN, `IMASK_RESET);
                    ev_set[`EVT_RESET] = 1'b1;
                end
                else if (q.is_irq)
                begin
                    d.sr_val = with_mask(q.sr_save, q.irq_lvl);
                end
                else
                begin
                    d.sr_val = q.sr_save;
                end
                d.is_reset = 1'b0;
            end
            default:
            begin
                d.st = ST_IDLE;
            end
        endcase
        // Register writes; the vector base is software-loadable.
        if (REG_WR)
        begin
            case (REG_ADDR)
                `REG_EVT_OFS:  ev_clr = REG_WDATA[5:0];
                `REG_MASK_OFS: d.mask = REG_WDATA[5:0];
                `REG_VEC_BASE_OFS: d.vector_base_reg = REG_WDATA;
                default:       ev_clr = 6'h00;
            endcase
        end
        // A new event wins over a simultaneous clear.
        d.evt = (q.evt & ~ev_clr) | ev_set;
        // Register reads answer in the next cycle; unmapped reads return zero.
        if (REG_RD)
        begin
            case (REG_ADDR)
                `REG_EVT_OFS:   d.rdata = {26'h0, q.evt};
                `REG_MASK_OFS:  d.rdata = {26'h0, q.mask};
                `REG_VEC_BASE_OFS: d.rdata = q.vector_base_reg;
                `REG_STATE_OFS: d.rdata = {16'h0, q.vec, 2'b00, q.pend_irq, q.pend_ae, 1'b0,
                                           q.st};
                default:        d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ======================================================================
    // State register
    // Reset lands in the first vector fetch, so handling begins at release.
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            q <= '0;
            q.st <= ST_RST_PC;
            q.is_reset <= 1'b1;
            q.mem_addr <= `RESET_PC_ADDR;
            q.vector_base_reg <= `VEC_BASE_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    // ======================================================================
    // Outputs
    assign MEM_REQ   = mem_state;
    assign MEM_WE    = q.mem_we;
    assign MEM_ADDR  = q.mem_addr;
    assign MEM_WDATA = q.mem_wdata;
    assign BUSY      = (q.st != ST_IDLE);
    assign IRQ_ACK   = q.irq_ack;
    assign PC_LOAD   = q.pc_load;
    assign PC_VALUE  = q.pc;
    assign SP_LOAD   = q.sp_load;
    assign SP_VALUE  = q.sp;
    assign SR_LOAD   = q.sr_load;
    assign SR_VALUE  = q.sr_val;
    assign VEC_BASE  = q.vector_base_reg;
    assign REG_RDATA = q.rdata;
    assign INT_OUT   = |(q.evt & q.mask);

    // ======================================================================
    // Assertions
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    // The second push may wait a few cycles for its acknowledge.
    sequence s_push_done;
        ((q.st == ST_PUSH_SR) && MEM_ACK) ##[1:8] ((q.st == ST_PUSH_PC) && MEM_ACK);
    endsequence

    property p_rst_pc_addr;
        (q.st == ST_RST_PC) |-> MEM_REQ && !MEM_WE && (MEM_ADDR == `RESET_PC_ADDR);
    endproperty
    a_rst_pc_addr: assert property (p_rst_pc_addr) else $error("reset PC fetch address wrong");

    property p_rst_sp_addr;
        (q.st == ST_RST_PC) && MEM_ACK |=> (q.st == ST_RST_SP) && (MEM_ADDR == `RESET_SP_ADDR);
    endproperty
    a_rst_sp_addr: assert property (p_rst_sp_addr) else $error("reset SP fetch address wrong");

    property p_rst_finish;
        (q.st == ST_FINISH) && q.is_reset |=> PC_LOAD && (VEC_BASE == `VEC_BASE_RESET) &&
            (SR_VALUE[`IMASK_LSB +: 4] == `IMASK_RESET) && (PC_VALUE == $past(q.pc));
    endproperty
    a_rst_finish: assert property (p_rst_finish) else $error("reset did not set base/mask");

    property p_pend_waits;
        (q.st == ST_IDLE) && q.pend_ae && !INSN_DONE |=> q.pend_ae && (q.st == ST_IDLE);
    endproperty
    a_pend_waits: assert property (p_pend_waits) else $error("address error started early");

    property p_trap_start;
        start_trap |=> (q.st == ST_PUSH_SR) && (q.vec >= `VEC_TRAP_FIRST) &&
            (q.vec <= `VEC_TRAP_LAST);
    endproperty
    a_trap_start: assert property (p_trap_start) else $error("trap did not start");

    property p_gen_ill;
        start_ill && !DEC_IN_SLOT |=> (q.vec == `VEC_GEN_ILLEGAL);
    endproperty
    a_gen_ill: assert property (p_gen_ill) else $error("general illegal vector wrong");

    property p_slot_ill;
        start_ill && DEC_IN_SLOT |=> (q.vec == `VEC_SLOT_ILLEGAL);
    endproperty
    a_slot_ill: assert property (p_slot_ill) else $error("slot illegal vector wrong");

    property p_push_order;
        s_push_done |=> (q.st == ST_VEC) && !MEM_WE && (SP_VALUE == $past(MEM_ADDR)) &&
            (MEM_ADDR == VEC_BASE + {22'h0, q.vec, 2'b00});
    endproperty
    a_push_order: assert property (p_push_order) else $error("push or vector address wrong");

    property p_irq_mask;
        (q.st == ST_FINISH) && q.is_irq |=> SR_LOAD &&
            (SR_VALUE[`IMASK_LSB +: 4] == $past(q.irq_lvl));
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("interrupt mask not loaded");

    property p_keep_mask;
        (q.st == ST_FINISH) && !q.is_irq && !q.is_reset |=> (SR_VALUE == $past(q.sr_save));
    endproperty
    a_keep_mask: assert property (p_keep_mask) else $error("mask changed on non-interrupt");

    property p_vec_load;
        (q.st == ST_VEC) && MEM_ACK |=> ##1 PC_LOAD && (PC_VALUE == $past(MEM_RDATA, 2));
    endproperty
    a_vec_load: assert property (p_vec_load) else $error("handler address not loaded");

endmodule

//--- src/exc_seq_consts.svh
// Offsets, field positions, reset values and vector numbers of the exception sequencer.
`ifndef EXC_SEQ_CONSTS_SVH
`define EXC_SEQ_CONSTS_SVH
`define REG_EVT_OFS      8'h00
`define REG_MASK_OFS     8'h04
`define REG_VEC_BASE_OFS 8'h08
`define REG_STATE_OFS    8'h0c
`define RESET_PC_ADDR    32'h0000_0000
`define RESET_SP_ADDR    32'h0000_0004
`define VEC_BASE_RESET   32'h0000_0000
`define IMASK_LSB        4
`define IMASK_RESET      4'hf
`define VEC_GEN_ILLEGAL  8'h04
`define VEC_SLOT_ILLEGAL 8'h06
`define VEC_ADDR_ERROR   8'h09
`define VEC_NMI          8'h0b
`define VEC_TRAP_FIRST   8'h20
`define VEC_TRAP_LAST    8'h3f
`define STACK_WORD       32'h0000_0004
`define EVT_RESET        0
`define EVT_ADDR_ERR     1
`define EVT_IRQ          2
`define EVT_GEN_ILL      3
`define EVT_SLOT_ILL     4
`define EVT_TRAP         5
`define EVT_WIDTH        6
`endif

//--- src/exc_seq_pkg.sv
// Types shared by the exception sequencer.
package exc_seq_pkg;
    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_RST_PC,
        ST_RST_SP,
        ST_PUSH_SR,
        ST_PUSH_PC,
        ST_VEC,
        ST_FINISH
    } seq_state_t;

    typedef struct packed
    {
        seq_state_t  st;
        logic [31:0] vector_base_reg;
        logic [7:0]  vec;
        logic        is_reset;
        logic        pend_ae;
        logic        pend_irq;
        logic [3:0]  pend_lvl;
        logic [7:0]  pend_vec;
        logic        is_irq;
        logic [3:0]  irq_lvl;
        logic [31:0] sp;
        logic [31:0] pc;
        logic [31:0] sr_save;
        logic        mem_we;
        logic [31:0] mem_addr;
        logic [31:0] mem_wdata;
        logic        pc_load;
        logic        sp_load;
        logic        sr_load;
        logic [31:0] sr_val;
        logic        irq_ack;
        logic [5:0]  evt;
        logic [5:0]  mask;
        logic [31:0] rdata;
    } seq_regs_t;
endpackage

//--- test/exc_mem_model.sv
// Word memory model that answers the sequencer's stack pushes and vector reads.
`timescale 1ns/10ps

module exc_mem_model
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        req,
    input  wire logic        we,
    input  wire logic [31:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic [1:0]  dly,
    output logic             ack,
    output logic [31:0]      rdata,
    output logic [31:0]      pwa,
    output logic [31:0]      pwd,
    output logic [31:0]      lwa,
    output logic [31:0]      lwd,
    output logic [31:0]      ra
);
    logic [1:0]  cnt;
    logic [31:0] last;

    // Vector table is filled before any exception can be taken.
    function automatic logic [31:0] word_at(input logic [31:0] a);
        word_at = (a == 32'h0) ? 32'h0000_1000 : (a == 32'h4) ? 32'h0000_8000 : 32'h00ab_0000 | a;
    endfunction

    // Acks after dly waits; between acks the data lines show the inverse of the last word.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ack   <= 1'b0;
            cnt   <= 2'd0;
            last  <= 32'h0;
            rdata <= 32'h0;
        end
        else
        begin
            ack   <= 1'b0;
            rdata <= ~last;
            if (req && !ack)
            begin
                if (cnt == dly)
                begin
                    ack <= 1'b1;
                    cnt <= 2'd0;
                    if (we)
                    begin
                        pwa <= lwa;
                        pwd <= lwd;
                        lwa <= addr;
                        lwd <= wdata;
                    end
                    else
                    begin
                        rdata <= word_at(addr);
                        last  <= word_at(addr);
                        ra    <= addr;
                    end
                end
                else
                    cnt <= cnt + 2'd1;
            end
        end
    end
endmodule

//--- test/cpu_exception_sequencer_test.sv
// Self-checking testbench of the exception sequencer.
`timescale 1ns/10ps
`include "exc_seq_consts.svh"

module cpu_exception_sequencer_test;
    typedef struct { int kind; logic [7:0] tv; logic [3:0] lvl; logic [7:0] vec; int evt;
                     logic [1:0] dly; } row_t;
    logic        CLK = 0, ARST_N = 0, DEC_VALID = 0, DEC_UNDEF = 0, DEC_IN_SLOT = 0;
    logic        DEC_PC_WRITE = 0, DEC_ADDR_ERR = 0, INSN_DONE = 0, TRAP_EXEC = 0;
    logic        IRQ_REQ = 0, IRQ_NMI = 0, REG_WR = 0, REG_RD = 0, MEM_ACK;
    logic [7:0]  TRAP_VEC = 0, IRQ_VEC = 8'h40, REG_ADDR = 0;
    logic [3:0]  IRQ_LEVEL = 0;
    logic [1:0]  dly = 0;
    logic [31:0] RET_PC = 32'h0000_2468, SR_IN = 32'h0000_0350, SP_IN = 32'h0000_7f00;
    logic [31:0] REG_WDATA = 0, MEM_RDATA, MEM_ADDR, MEM_WDATA, PC_VALUE, SP_VALUE;
    logic [31:0] SR_VALUE, VEC_BASE, REG_RDATA, pwa, pwd, lwa, lwd, ra, rd, exp_sr;
    logic        IRQ_ACK, MEM_REQ, MEM_WE, BUSY, PC_LOAD, SP_LOAD, SR_LOAD, INT_OUT;
    int          failures = 0, checks_done = 0, cyc = 0, acks = 0, acks0;
    row_t        rows [8];

    exc_seq i_exc_seq (.CLK(CLK), .ARST_N(ARST_N), .DEC_VALID(DEC_VALID),
        .DEC_UNDEF(DEC_UNDEF), .DEC_IN_SLOT(DEC_IN_SLOT), .DEC_PC_WRITE(DEC_PC_WRITE),
        .DEC_ADDR_ERR(DEC_ADDR_ERR), .INSN_DONE(INSN_DONE), .TRAP_EXEC(TRAP_EXEC),
        .TRAP_VEC(TRAP_VEC), .IRQ_REQ(IRQ_REQ), .IRQ_NMI(IRQ_NMI), .IRQ_LEVEL(IRQ_LEVEL),
        .IRQ_VEC(IRQ_VEC), .IRQ_ACK(IRQ_ACK), .RET_PC(RET_PC), .SR_IN(SR_IN), .SP_IN(SP_IN),
        .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
        .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .BUSY(BUSY), .PC_LOAD(PC_LOAD),
        .PC_VALUE(PC_VALUE), .SP_LOAD(SP_LOAD), .SP_VALUE(SP_VALUE), .SR_LOAD(SR_LOAD),
        .SR_VALUE(SR_VALUE), .VEC_BASE(VEC_BASE), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .INT_OUT(INT_OUT));

    exc_mem_model i_exc_mem_model (.clk(CLK), .arst_n(ARST_N), .req(MEM_REQ), .we(MEM_WE),
        .addr(MEM_ADDR), .wdata(MEM_WDATA), .dly(dly), .ack(MEM_ACK), .rdata(MEM_RDATA),
        .pwa(pwa), .pwd(pwd), .lwa(lwa), .lwd(lwd), .ra(ra));

    // ======================================================================
    // Clock, interrupt acknowledge counting and the hang limit.
    always #25 CLK = ~CLK;

    always @(posedge CLK)
    begin
        cyc++;
        if (IRQ_ACK === 1'b1)
            acks++;
        if (cyc == 20000)
        begin
            failures++;
            final_report();
        end
    end

    // ======================================================================
    // Shared tasks.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        REG_WR    <= 1'b1;
        REG_ADDR  <= a;
        REG_WDATA <= d;
        @(posedge CLK);
        REG_WR    <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge CLK);
        REG_RD   <= 1'b1;
        REG_ADDR <= a;
        @(posedge CLK);
        REG_RD   <= 1'b0;
        #1 d = REG_RDATA;
    endtask

    // Waits a bounded time for the load pulse that ends a sequence.
    task automatic wait_load();
        int n;
        n = 0;
        do
        begin
            @(posedge CLK);
            #1 n++;
        end
        while (PC_LOAD !== 1'b1 && n < 300);
        check("load pulse", {31'h0, PC_LOAD}, 32'h1);
        check("sp load", {31'h0, SP_LOAD}, 32'h1);
        check("sr load", {31'h0, SR_LOAD}, 32'h1);
    endtask

    task automatic check_reset();
        wait_load();
        check("reset pc", PC_VALUE, 32'h0000_1000);
        check("reset sp", SP_VALUE, 32'h0000_8000);
        check("last read", ra, 32'h0000_0004);
        check("reset mask", {28'h0, SR_VALUE[`IMASK_LSB+:4]}, 32'hf);
        check("reset vector base", VEC_BASE, 32'h0);
    endtask

    // Presents one exception source for a cycle; deferred kinds then complete an instruction.
    task automatic fire(input row_t r);
        @(posedge CLK);
        DEC_VALID    <= (r.kind != 6);
        DEC_ADDR_ERR <= (r.kind == 0);
        IRQ_REQ      <= (r.kind == 1) || (r.kind == 2);
        IRQ_NMI      <= (r.kind == 2);
        IRQ_LEVEL    <= r.lvl;
        DEC_UNDEF    <= (r.kind == 3) || (r.kind == 4);
        DEC_IN_SLOT  <= (r.kind == 4) || (r.kind == 5) || (r.kind == 8);
        DEC_PC_WRITE <= (r.kind == 5) || (r.kind == 7);
        TRAP_EXEC    <= (r.kind == 6);
        TRAP_VEC     <= r.tv;
        @(posedge CLK);
        {DEC_VALID, DEC_ADDR_ERR, IRQ_REQ, IRQ_NMI} <= 4'h0;
        {DEC_UNDEF, DEC_IN_SLOT, DEC_PC_WRITE, TRAP_EXEC} <= 4'h0;
        if (r.kind < 3)
        begin
            repeat (3) @(posedge CLK);
            #1 check("busy before done", {31'h0, BUSY}, 32'h0);
            @(posedge CLK);
            INSN_DONE <= 1'b1;
            @(posedge CLK);
            INSN_DONE <= 1'b0;
        end
    endtask

    // ======================================================================
    // Main sequence: reset, table of exception kinds, then the awkward cases.
    initial
    begin
        rows = '{'{0, 8'h00, 4'h0, 8'd9, `EVT_ADDR_ERR, 2'd0},
                 '{1, 8'h00, 4'h7, 8'h40, `EVT_IRQ, 2'd1},
                 '{2, 8'h00, 4'hc, 8'd11, `EVT_IRQ, 2'd0},
                 '{3, 8'h00, 4'h0, 8'd4, `EVT_GEN_ILL, 2'd3},
                 '{4, 8'h00, 4'h0, 8'd6, `EVT_SLOT_ILL, 2'd0},
                 '{5, 8'h00, 4'h0, 8'd6, `EVT_SLOT_ILL, 2'd2},
                 '{6, 8'h00, 4'h0, 8'd32, `EVT_TRAP, 2'd0},
                 '{6, 8'h1f, 4'h0, 8'd63, `EVT_TRAP, 2'd3}};
        repeat (8) @(posedge CLK);
        #1 check("busy in reset", {31'h0, BUSY}, 32'h1);
        check("addr in reset", MEM_ADDR, 32'h0);
        check("req in reset", {31'h0, MEM_REQ}, 32'h1);
        @(posedge CLK);
        ARST_N <= 1'b1;
        check_reset();
        reg_wr(`REG_MASK_OFS, 32'h3f);
        reg_wr(`REG_EVT_OFS, 32'h3f);
        reg_wr(`REG_VEC_BASE_OFS, 32'h4000);
        reg_rd(`REG_VEC_BASE_OFS, rd);
        check("vector base", rd, 32'h4000);
        foreach (rows[i])
        begin
            dly   <= rows[i].dly;
            acks0 = acks;
            fire(rows[i]);
            wait_load();
            exp_sr = SR_IN;
            if (rows[i].kind == 1 || rows[i].kind == 2)
                exp_sr[`IMASK_LSB+:4] = rows[i].lvl;
            check("vector read", ra, 32'h4000 + {22'h0, rows[i].vec, 2'b00});
            check("handler pc", PC_VALUE, 32'h00ab_4000 | {22'h0, rows[i].vec, 2'b00});
            check("sr push addr", pwa, SP_IN - 32'd4);
            check("sr push data", pwd, SR_IN);
            check("pc push addr", lwa, SP_IN - 32'd8);
            check("pc push data", lwd, RET_PC);
            check("sr loaded", SR_VALUE, exp_sr);
            check("irq acks", acks - acks0, (rows[i].evt == `EVT_IRQ));
            reg_rd(`REG_EVT_OFS, rd);
            check("event bit", rd, 32'h1 << rows[i].evt);
            check("int high", {31'h0, INT_OUT}, 32'h1);
            reg_wr(`REG_EVT_OFS, 32'h3f);
            @(posedge CLK);
            #1 check("int low", {31'h0, INT_OUT}, 32'h0);
        end
        // PC write outside a slot and a plain slot instruction raise nothing.
        fire(row_t'{7, 8'h00, 4'h0, 8'h00, 0, 2'h0});
        fire(row_t'{8, 8'h00, 4'h0, 8'h00, 0, 2'h0});
        repeat (3) @(posedge CLK);
        #1 check("no exception", {31'h0, BUSY}, 32'h0);
        // A masked event stays silent until unmasked.
        reg_wr(`REG_MASK_OFS, 32'h0);
        fire(rows[6]);
        wait_load();
        check("masked int", {31'h0, INT_OUT}, 32'h0);
        reg_wr(`REG_MASK_OFS, 32'h3f);
        @(posedge CLK);
        #1 check("unmasked int", {31'h0, INT_OUT}, 32'h1);
        reg_rd(8'hf0, rd);
        check("unmapped read", rd, 32'h0);
        // Idle state register shows the last vector, the first trap number.
        reg_rd(`REG_STATE_OFS, rd);
        check("state reg", rd, 32'h0000_2000);
        // Second reset in mid-sequence restarts reset handling.
        reg_wr(`REG_VEC_BASE_OFS, 32'h4000);
        fire(rows[3]);
        @(posedge CLK);
        ARST_N <= 1'b0;
        @(posedge CLK);
        #1 check("vector base in reset", VEC_BASE, 32'h0);
        @(posedge CLK);
        ARST_N <= 1'b1;
        check_reset();
        final_report();
    end
endmodule
